// file: logic/atc_pkg.sv
`default_nettype none
package atc_pkg;

  // ------------------------------------------------------------------
  // Widths and counts
  // ------------------------------------------------------------------
  localparam int unsigned PHASE_W = 20;
  localparam int unsigned SAMPLE_W = 2;
  localparam int unsigned FIFO_W = 2;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned BITCNT_W = 4;

  localparam logic [PHASE_W-1:0] PHASE_MAX = 20'hfffff;
  localparam logic [PHASE_W-1:0] PHASE_ONE = 20'h00001;
  localparam logic [PHASE_W-1:0] PERIOD_RESET = 20'hfffff;
  localparam logic [BITCNT_W-1:0] BITCNT_ONE = 4'h1;

  // ------------------------------------------------------------------
  // Turnaround delay selection
  // ------------------------------------------------------------------
  localparam logic [1:0] DELAY_SEL_LONG = 2'h0;
  localparam logic [1:0] DELAY_SEL_MEDIUM = 2'h1;
  localparam logic [1:0] DELAY_SEL_SHORT = 2'h2;
  localparam logic [BITCNT_W-1:0] DELAY_LONG_BITS = 4'hb;
  localparam logic [BITCNT_W-1:0] DELAY_MEDIUM_BITS = 4'h6;
  localparam logic [BITCNT_W-1:0] DELAY_SHORT_BITS = 4'h2;

  // ------------------------------------------------------------------
  // Driver states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ATC_IDLE = 2'b01,
    ATC_DRIVE = 2'b10
  } atc_state_type;

endpackage
`default_nettype wire

// file: logic/atc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module atc_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;

  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign do_wr = i_in_valid && o_in_ready;
  assign do_rd = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  // Head word is registered so the consumer sees stable data.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_out_data <= '1;
    end else begin
      o_out_data <= (do_rd && count > (AW+1)'(1)) ?
        mem[rd_ptr == AW'(DEPTH - 1) ? '0 : rd_ptr + 1'b1] :
        (do_wr && !o_out_valid) ||
        (do_wr && do_rd && count == (AW+1)'(1)) ?
        i_in_data : mem[rd_ptr];
    end
  end

endmodule
`default_nettype wire

// file: logic/atc_top.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Time each high and low serial phase; derive bit period from them.
// - First Zero enables the bus driver and drives that Zero negative.
// - While enabled, forward every bit unaltered to the bus.
// - Serial line continuously One for the set delay disables the driver.
// - Driver enable is the half-duplex direction: on transmit, off receive.
// - Long setting holds driver for 11 One bit times.
// - Long setting, 8N1 ending in Zero, turns 10 bits after character.
// - Medium setting disables after 6 One bit times.
// - Short setting disables after 2 One bit times, even mid-character.
// - Driver dropped within a character re-enables on the next Zero.
// - Receive is ready immediately once the driver is disabled.
module atc_top (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  // Configuration
  input wire logic [1:0] I_DELAY_SEL,
  // Host serial side
  input wire logic I_SER_TXD,
  output logic O_SER_RXD,
  // Bus side
  output logic O_BUS_DATA,
  output logic O_BUS_DRV_EN,
  output logic O_BUS_RX_EN,
  input wire logic I_BUS_RXD,
  // Status
  output logic [atc_pkg::PHASE_W-1:0] O_BIT_PERIOD,
  output logic O_FIFO_OVERRUN
);

  // ------------------------------------------------------------------
  // Input stream buffer
  // ------------------------------------------------------------------
  // The line is sampled every clock and pushed with an edge marker; the
  // FIFO decouples sampling from the driver path by a fixed small latency.
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [atc_pkg::FIFO_W-1:0] fifo_out_data;
  logic ser_d;
  logic ser_edge;
  logic cur;

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      ser_d <= 1'b1;
    end else begin
      ser_d <= I_SER_TXD;
    end
  end
  assign ser_edge = (I_SER_TXD != ser_d);

  atc_fifo #(
    .WIDTH(atc_pkg::FIFO_W),
    .DEPTH(atc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CORE_CLK),
    .i_rst_b(I_RST_B),
    .i_in_valid(1'b1),
    .o_in_ready(fifo_in_ready),
    .i_in_data({ser_edge, I_SER_TXD}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(1'b1),
    .o_out_data(fifo_out_data)
  );

  // Drain runs every cycle, so overrun only flags a broken buffer.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      O_FIFO_OVERRUN <= 1'b0;
    end else if (!fifo_in_ready) begin
      O_FIFO_OVERRUN <= 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      cur <= 1'b1;
    end else if (fifo_out_valid) begin
      cur <= fifo_out_data[0];
    end
  end

  // ------------------------------------------------------------------
  // Phase measurement
  // ------------------------------------------------------------------
  logic [atc_pkg::PHASE_W-1:0] phase_len;
  logic [atc_pkg::PHASE_W-1:0] bit_period;
  logic phase_end;
  logic phase_seen;

  assign phase_end = fifo_out_valid && fifo_out_data[1];

  // The phase from reset to the first edge has no true start, so it must
  // not set the estimate; only phases framed by two edges count.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      phase_seen <= 1'b0;
    end else if (phase_end) begin
      phase_seen <= 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      phase_len <= atc_pkg::PHASE_ONE;
    end else if (phase_end) begin
      phase_len <= atc_pkg::PHASE_ONE;
    end else if (phase_len != atc_pkg::PHASE_MAX) begin
      phase_len <= phase_len + atc_pkg::PHASE_ONE;
    end
  end

  // The shortest phase seen is one bit; longer phases are multiples.
  // A short burst can leave the estimate too slow, delaying turnaround.
  // A slow estimate only stretches the turnaround; it never cuts a bit.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      bit_period <= atc_pkg::PERIOD_RESET;
    end else if (phase_end && phase_seen && phase_len < bit_period) begin
      bit_period <= phase_len;
    end
  end
  assign O_BIT_PERIOD = bit_period;

  // ------------------------------------------------------------------
  // Delay selection
  // ------------------------------------------------------------------
  logic [atc_pkg::BITCNT_W-1:0] delay_bits;
  logic [atc_pkg::BITCNT_W-1:0] next_delay_bits;

  // Code 3 is not a setting of its own; it falls back to the safest delay.
  always_comb begin
    case (I_DELAY_SEL)
      atc_pkg::DELAY_SEL_MEDIUM: next_delay_bits = atc_pkg::DELAY_MEDIUM_BITS;
      atc_pkg::DELAY_SEL_SHORT: next_delay_bits = atc_pkg::DELAY_SHORT_BITS;
      default: next_delay_bits = atc_pkg::DELAY_LONG_BITS;
    endcase
  end

  // ------------------------------------------------------------------
  // Driver control
  // ------------------------------------------------------------------
  atc_pkg::atc_state_type state;
  logic [atc_pkg::PHASE_W-1:0] tick;
  logic [atc_pkg::BITCNT_W-1:0] ones;
  logic bit_done;
  logic run_done;

  assign bit_done = (tick >= bit_period);
  assign run_done = bit_done && (ones + atc_pkg::BITCNT_ONE >= delay_bits);

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      state <= atc_pkg::ATC_IDLE;
    end else begin
      case (state)
        atc_pkg::ATC_IDLE: begin
          if (!cur) begin
            state <= atc_pkg::ATC_DRIVE;
          end
        end
        atc_pkg::ATC_DRIVE: begin
          if (cur && run_done) begin
            state <= atc_pkg::ATC_IDLE;
          end
        end
        default: state <= atc_pkg::ATC_IDLE;
      endcase
    end
  end

  // The count ends on the bit boundary, so a run of exactly the set length
  // also turns the bus; the next Zero brings the driver back.
  // One-bit timer runs only while the line rests at One.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      tick <= atc_pkg::PHASE_ONE;
      ones <= '0;
    end else if (!cur || state != atc_pkg::ATC_DRIVE) begin
      tick <= atc_pkg::PHASE_ONE;
      ones <= '0;
    end else if (bit_done) begin
      tick <= atc_pkg::PHASE_ONE;
      ones <= ones + atc_pkg::BITCNT_ONE;
    end else begin
      tick <= tick + atc_pkg::PHASE_ONE;
    end
  end

  // Setting latched only while idle so a run in progress is not altered.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      delay_bits <= atc_pkg::DELAY_LONG_BITS;
    end else if (state == atc_pkg::ATC_IDLE) begin
      delay_bits <= next_delay_bits;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Receive data is held at One while driving, so the host never hears
  // its own echo from the bus.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      O_BUS_DATA <= 1'b1;
      O_SER_RXD <= 1'b1;
    end else begin
      O_BUS_DATA <= cur;
      O_SER_RXD <= (state == atc_pkg::ATC_IDLE) ? I_BUS_RXD : 1'b1;
    end
  end

  // Direction comes straight from the state register, so it cannot glitch.
  assign O_BUS_DRV_EN = (state == atc_pkg::ATC_DRIVE);
  assign O_BUS_RX_EN = (state == atc_pkg::ATC_IDLE);

endmodule
`default_nettype wire

// file: verification/atc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module atc_monitor (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  // Watched ports
  input wire logic [1:0] I_DELAY_SEL,
  input wire logic I_SER_TXD,
  input wire logic O_SER_RXD,
  input wire logic O_BUS_DATA,
  input wire logic O_BUS_DRV_EN,
  input wire logic O_BUS_RX_EN,
  input wire logic I_BUS_RXD,
  input wire logic [atc_pkg::PHASE_W-1:0] O_BIT_PERIOD,
  input wire logic O_FIFO_OVERRUN
);
  logic [31:0] hi;
  logic [31:0] bits;
  logic [31:0] lim;
  assign bits = I_DELAY_SEL == 2'h1 ? 32'h6 :
                I_DELAY_SEL == 2'h2 ? 32'h2 : 32'hb;
  assign lim = bits * O_BIT_PERIOD;
  // The high run is counted here, so a wrong delay constant shows at once.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_B || !I_SER_TXD) begin
      hi <= 32'h0;
    end else begin
      hi <= hi + 32'h1;
    end
  end
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);
  property p_dir; O_BUS_RX_EN == !O_BUS_DRV_EN; endproperty
  a_dir: assert property (p_dir) else $error("direction mismatch");
  property p_start; $fell(I_SER_TXD) |-> ##[1:5] O_BUS_DRV_EN; endproperty
  a_start: assert property (p_start) else $error("no enable");
  property p_zero; $rose(O_BUS_DRV_EN) |-> ##[0:2] !O_BUS_DATA; endproperty
  a_zero: assert property (p_zero) else $error("start not Zero");
  property p_copy;
    O_BUS_DRV_EN && $past(I_SER_TXD, 3) == $past(I_SER_TXD, 4)
      |-> O_BUS_DATA == $past(I_SER_TXD, 3);
  endproperty
  a_copy: assert property (p_copy) else $error("bit altered");
  property p_low; !I_SER_TXD [*5] |-> O_BUS_DRV_EN; endproperty
  a_low: assert property (p_low) else $error("Zero not driven");
  property p_hold; $fell(O_BUS_DRV_EN) |-> $past(hi, 2) >= lim; endproperty
  a_hold: assert property (p_hold) else $error("early drop");
  property p_timely; O_BUS_DRV_EN |-> hi <= lim + 32'h10; endproperty
  a_timely: assert property (p_timely) else $error("late drop");
  property p_rx;
    !O_BUS_DRV_EN && !$past(O_BUS_DRV_EN) && !$past(O_BUS_DRV_EN, 2)
      |-> O_SER_RXD == $past(I_BUS_RXD);
  endproperty
  a_rx: assert property (p_rx) else $error("receive not ready");
  property p_period; O_BIT_PERIOD <= $past(O_BIT_PERIOD); endproperty
  a_period: assert property (p_period) else $error("period grew");
endmodule
bind atc_top atc_monitor i_atc_monitor (.*);
`default_nettype wire

// file: verification/atc_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module atc_bus_model (
  // Device driver side
  input wire logic i_drv_en,
  input wire logic i_data,
  // Remote station
  input wire logic i_rem_en,
  input wire logic i_rem_data,
  // Resolved line
  output logic o_line
);
  // Polarization holds a released bus at One, so an early drop reads Stop.
  assign o_line = i_drv_en ? i_data : (i_rem_en ? i_rem_data : 1'b1);
endmodule
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
  localparam int B = 16;
  logic clk, rst_b, txd, rem_en, rem_d, line;
  logic [1:0] sel;
  logic rxd, bdata, drv, rxen, ovr;
  logic [atc_pkg::PHASE_W-1:0] per;
  int miscompares = 0;
  int checks = 0;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  atc_top i_atc_top (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_DELAY_SEL(sel),
    .I_SER_TXD(txd), .O_SER_RXD(rxd), .O_BUS_DATA(bdata),
    .O_BUS_DRV_EN(drv), .O_BUS_RX_EN(rxen), .I_BUS_RXD(line),
    .O_BIT_PERIOD(per), .O_FIFO_OVERRUN(ovr));
  atc_bus_model i_atc_bus_model (.i_drv_en(drv), .i_data(bdata),
    .i_rem_en(rem_en), .i_rem_data(rem_d), .o_line(line));
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic send(input logic [7:0] b, output logic [7:0] g,
                      output logic d);
    logic [8:0] f;
    f = {b, 1'b0};
    d = 1'b0;
    @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      txd <= f[i];
      repeat (B / 2) @(posedge clk);
      @(negedge clk);
      if (i == 0) `CHK(line, 1'b0)
      else g[i-1] = line;
      if (drv !== 1'b1 && i > 0) d = 1'b1;
      repeat (B / 2) @(posedge clk);
    end
    txd <= 1'b1;
    @(posedge clk);
  endtask
  task automatic drop(input int n);
    int t;
    t = 0;
    while (drv !== 1'b0 && t < 4000) begin
      @(negedge clk);
      t++;
    end
    if (t >= 4000) begin
      miscompares++;
      report_and_stop();
    end else begin
      `CHK(t >= n * B - 2 && t <= n * B + 8, 1'b1)
      @(posedge clk);
    end
  endtask
  task automatic test_forward;
    logic [7:0] g;
    logic d;
    `CHK({drv, rxen, bdata, rxd, per}, {4'h7, 20'hfffff})
    send(8'h55, g, d);
    `CHK(g, 8'h55)
    `CHK(d, 1'b0)
    `CHK(per >= 20'hf && per <= 20'h11, 1'b1)
    drop(11);
    $display("test_forward done");
  endtask
  task automatic test_delays;
    logic [7:0] g;
    logic d;
    int n [4] = '{11, 6, 2, 11};
    for (int s = 1; s < 4; s++) begin
      sel <= s[1:0];
      repeat (4) @(posedge clk);
      send(8'h35, g, d);
      `CHK(g, 8'h35)
      drop(n[s]);
    end
    $display("test_delays done");
  endtask
  task automatic test_short_gap;
    logic [7:0] g;
    logic d;
    sel <= 2'h2;
    send(8'h0f, g, d);
    `CHK(d, 1'b1)
    `CHK(g, 8'h0f)
    drop(2);
    $display("test_short_gap done");
  endtask
  task automatic test_rx;
    logic [2:0] v;
    v = 3'h2;
    rem_en <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rem_d <= v[i];
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK({rxd, rxen}, {v[i], 1'b1})
      `CHK(ovr, 1'b0)
      @(posedge clk);
    end
    rem_en <= 1'b0;
    $display("test_rx done");
  endtask
  initial begin
    rst_b = 1'b0;
    txd = 1'b1;
    sel = 2'h0;
    rem_en = 1'b0;
    rem_d = 1'b1;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    test_forward();
    test_delays();
    test_short_gap();
    test_rx();
    report_and_stop();
  end
endmodule
`default_nettype wire
